// ### rtl/trace_pkg.sv
// constants, field layout and types of the program flow trace buffer
package trace_pkg;

  // ==========================================================
  // register map
  localparam logic [31:0] REG_BASE   = 32'h4100_6000;
  localparam logic [11:0] POS_OFF    = 12'h000;
  localparam logic [11:0] MASTER_OFF = 12'h004;
  localparam logic [11:0] FLOW_OFF   = 12'h008;
  localparam logic [11:0] BASE_OFF   = 12'h00c;

  // ==========================================================
  // field positions
  localparam int POS_WRAP_BIT    = 2;
  localparam int PTR_LSB         = 3;
  localparam int MASTER_EN_BIT   = 31;
  localparam int MASK_LSB        = 0;
  localparam int MASK_W          = 5;
  localparam int FLOW_STOP_BIT   = 0;
  localparam int FLOW_HALT_BIT   = 1;
  localparam int REGION_MIN_LOG2 = 4;

  // ==========================================================
  // reset values
  localparam logic              EN_RST   = 1'h0;
  localparam logic [MASK_W-1:0] MASK_RST = 5'h00;

  // ==========================================================
  // packet and bus constants
  localparam int          PKT_W       = 64;
  localparam int          PKT_BYTES   = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [3:0]  ALL_BYTES   = 4'hf;

  typedef enum logic [0:0] {
    WR_FIRST  = 1'b0,
    WR_SECOND = 1'b1
  } wr_state_t;

endpackage

// ### rtl/fifo_if.sv
// valid/ready stream carrier between the trace modules
`timescale 1ns/1ps
`default_nettype none
interface fifo_if #(
  parameter int W = 64
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### rtl/trace_fifo.sv
// small synchronous fifo for trace packets
`timescale 1ns/1ps
`default_nettype none
module trace_fifo #(
  parameter int W     = 64,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  fifo_if.snk      inPort,
  fifo_if.src      outPort
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  store [DEPTH];
  logic [AW-1:0] wrIdx_q;
  logic [AW-1:0] rdIdx_q;
  logic [CW-1:0] count_q;
  logic          push;
  logic          pop;

  // ==========================================================
  // handshakes
  assign inPort.ready  = (count_q != CW'(DEPTH));
  assign outPort.valid = (count_q != '0);
  assign outPort.data  = store[rdIdx_q];
  assign push          = inPort.valid && inPort.ready;
  assign pop           = outPort.valid && outPort.ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] idx);
    bump = (idx == AW'(DEPTH - 1)) ? '0 : AW'(idx + 1'h1);
  endfunction

  // ==========================================================
  // storage and pointers
  always_ff @(posedge ref_clk) begin
    if (push) begin
      store[wrIdx_q] <= inPort.data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrIdx_q <= '0;
      rdIdx_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrIdx_q <= bump(wrIdx_q);
      end
      if (pop) begin
        rdIdx_q <= bump(rdIdx_q);
      end
      if (push && !pop) begin
        count_q <= CW'(count_q + 1'h1);
      end else if (pop && !push) begin
        count_q <= CW'(count_q - 1'h1);
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/program_trace_buffer.sv
// program flow trace recorder with shared SRAM and register slave
`timescale 1ns/1ps
`default_nettype none
module program_trace_buffer #(
  parameter int unsigned SRAM_WORDS    = 1024,
  parameter logic [31:0] SRAM_MAP_BASE = 32'h2000_0000,
  parameter int unsigned FIFO_DEPTH    = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register slave
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // execution trace from the core
  input  wire logic        traceValid,
  output logic             traceReady,
  input  wire logic [31:0] traceSrcPc,
  input  wire logic [31:0] traceDstPc,
  input  wire logic        traceException,
  // processor and debug access to the SRAM
  input  wire logic        cpuReq,
  input  wire logic        cpuWe,
  input  wire logic [31:0] cpuAddr,
  input  wire logic [31:0] cpuWdata,
  input  wire logic [3:0]  cpuBe,
  output logic             cpuGnt,
  output logic             cpuRvalid,
  output logic [31:0]      cpuRdata,
  // status towards the core
  output logic             haltReq,
  output logic             traceActive
);
  localparam int IW = $clog2(SRAM_WORDS);
  localparam int PW = IW + 2;

  // ==========================================================
  // helpers
  function automatic logic regHit(input logic [31:0] a, input logic [11:0] off);
    regHit = (a[31:12] == trace_pkg::REG_BASE[31:12]) && (a[11:0] == off);
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      mergeBytes[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // ones over the low bits covered by the circular region
  function automatic logic [PW-1:0] regionMask(input logic [4:0] m);
    for (int i = 0; i < PW; i++) begin
      regionMask[i] = (i < int'(m) + trace_pkg::REGION_MIN_LOG2);
    end
  endfunction

  // ==========================================================
  // state
  logic [PW-1:3]                  posPtr_q;
  logic                           posWrap_q;
  logic                           en_q;
  logic [trace_pkg::MASK_W-1:0]   mask_q;
  logic [PW-1:3]                  wmark_q;
  logic                           auto_stop_select_q;
  logic                           auto_halt_select_q;
  logic                           haltReq_q;
  trace_pkg::wr_state_t           wrState_q;
  logic                           awHeld_q;
  logic [31:0]                    awAddr_q;
  logic                           wHeld_q;
  logic [31:0]                    wData_q;
  logic [3:0]                     wStrb_q;
  logic                           bvalid_q;
  logic [1:0]                     bresp_q;
  logic                           rvalid_q;
  logic [1:0]                     rresp_q;
  logic [31:0]                    rdata_q;
  logic                           cpuRvalid_q;
  logic [31:0]                    cpuRdata_q;
  logic [31:0]                    sram [SRAM_WORDS];

  // ==========================================================
  // register views
  logic [31:0] posWord;
  logic [31:0] masterWord;
  logic [31:0] flowWord;
  logic [31:0] baseWord;

  assign posWord    = {{(32-PW){1'h0}}, posPtr_q, posWrap_q, 2'h0};
  assign masterWord = {en_q, 26'h0, mask_q};
  assign flowWord   = {{(32-PW){1'h0}}, wmark_q, 1'h0, auto_halt_select_q, auto_stop_select_q};
  assign baseWord   = SRAM_MAP_BASE;

  // ==========================================================
  // register slave, write side
  logic        awAccept;
  logic        wAccept;
  logic        doWrite;
  logic        wrPos;
  logic        wrMaster;
  logic        wrFlow;
  logic        wrBase;
  logic [31:0] wrOld;
  logic [31:0] wrNew;

  assign awready  = !awHeld_q && !bvalid_q;
  assign wready   = !wHeld_q && !bvalid_q;
  assign awAccept = awvalid && awready;
  assign wAccept  = wvalid && wready;
  assign doWrite  = awHeld_q && wHeld_q;
  assign wrPos    = doWrite && regHit(awAddr_q, trace_pkg::POS_OFF);
  assign wrMaster = doWrite && regHit(awAddr_q, trace_pkg::MASTER_OFF);
  assign wrFlow   = doWrite && regHit(awAddr_q, trace_pkg::FLOW_OFF);
  assign wrBase   = doWrite && regHit(awAddr_q, trace_pkg::BASE_OFF);
  assign wrOld    = wrPos ? posWord : wrMaster ? masterWord : flowWord;
  assign wrNew    = mergeBytes(wrOld, wData_q, wStrb_q);
  assign bvalid   = bvalid_q;
  assign bresp    = bresp_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'h0;
      awAddr_q <= 32'h0;
      wHeld_q  <= 1'h0;
      wData_q  <= 32'h0;
      wStrb_q  <= 4'h0;
      bvalid_q <= 1'h0;
      bresp_q  <= trace_pkg::RESP_OKAY;
    end else begin
      if (awAccept) begin
        awHeld_q <= 1'h1;
        awAddr_q <= awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'h0;
      end
      if (wAccept) begin
        wHeld_q <= 1'h1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'h0;
      end
      if (doWrite) begin
        bvalid_q <= 1'h1;
        bresp_q  <= (wrPos || wrMaster || wrFlow || wrBase) ?
                    trace_pkg::RESP_OKAY : trace_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'h0;
      end
    end
  end

  // ==========================================================
  // register slave, read side
  logic        arAccept;
  logic        rdPos;
  logic        rdMaster;
  logic        rdFlow;
  logic        rdBase;
  logic [31:0] rdWord;

  assign arready  = !rvalid_q;
  assign arAccept = arvalid && arready;
  assign rdPos    = regHit(araddr, trace_pkg::POS_OFF);
  assign rdMaster = regHit(araddr, trace_pkg::MASTER_OFF);
  assign rdFlow   = regHit(araddr, trace_pkg::FLOW_OFF);
  assign rdBase   = regHit(araddr, trace_pkg::BASE_OFF);
  assign rdWord   = rdPos ? posWord : rdMaster ? masterWord :
                    rdFlow ? flowWord : rdBase ? baseWord : 32'h0;
  assign rvalid   = rvalid_q;
  assign rresp    = rresp_q;
  assign rdata    = rdata_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'h0;
      rresp_q  <= trace_pkg::RESP_OKAY;
      rdata_q  <= 32'h0;
    end else if (arAccept) begin
      rvalid_q <= 1'h1;
      rdata_q  <= rdWord;
      rresp_q  <= (rdPos || rdMaster || rdFlow || rdBase) ?
                  trace_pkg::RESP_OKAY : trace_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'h0;
    end
  end

  // ==========================================================
  // packet capture
  // bit 0 of a halfword-aligned pc carries no address, so the source pc's bit 0 holds the exception flag and the destination's is zero
  fifo_if #(.W(trace_pkg::PKT_W)) pktIn ();
  fifo_if #(.W(trace_pkg::PKT_W)) pktOut ();

  assign pktIn.valid = traceValid && en_q;
  assign traceReady  = pktIn.ready && en_q;
  assign pktIn.data  = {traceDstPc[31:1], 1'h0,
                        traceSrcPc[31:1], traceException};
  assign traceActive = en_q;

  trace_fifo #(
    .W     (trace_pkg::PKT_W),
    .DEPTH (FIFO_DEPTH)
  ) pktQueue (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .inPort  (pktIn),
    .outPort (pktOut)
  );

  // ==========================================================
  // packet writer and pointer arithmetic
  logic [PW-1:0] ptrFull;
  logic [PW-1:0] ptrIncr;
  logic [PW-1:0] ptrMask;
  logic [PW-1:0] ptrNext;
  logic          wrapEv;
  logic          pktDone;
  logic          wmHit;
  logic          traceBusy;
  logic          traceWe;
  logic [IW-1:0] traceIdx;
  logic [31:0]   traceData;

  assign ptrFull   = {posPtr_q, 3'h0};
  assign ptrIncr   = PW'(ptrFull + PW'(trace_pkg::PKT_BYTES));
  assign ptrMask   = regionMask(mask_q);
  assign ptrNext   = (ptrFull & ~ptrMask) | (ptrIncr & ptrMask);
  assign wrapEv    = ((ptrIncr & ptrMask) == '0);
  assign traceWe   = pktOut.valid || (wrState_q == trace_pkg::WR_SECOND);
  assign traceBusy = traceWe;
  assign pktDone   = (wrState_q == trace_pkg::WR_SECOND);
  assign pktOut.ready = pktDone;
  assign traceIdx  = (wrState_q == trace_pkg::WR_SECOND) ?
                     {ptrFull[PW-1:3], 1'h1} : {ptrFull[PW-1:3], 1'h0};
  assign traceData = (wrState_q == trace_pkg::WR_SECOND) ?
                     pktOut.data[63:32] : pktOut.data[31:0];
  assign wmHit     = pktDone && (ptrNext[PW-1:3] == wmark_q);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrState_q <= trace_pkg::WR_FIRST;
    end else begin
      case (wrState_q)
        trace_pkg::WR_FIRST: begin
          if (pktOut.valid) begin
            wrState_q <= trace_pkg::WR_SECOND;
          end
        end
        default: begin
          wrState_q <= trace_pkg::WR_FIRST;
        end
      endcase
    end
  end

  // ==========================================================
  // shared SRAM, trace first
  // the processor only stalls, it never loses a request: it holds cpuReq
  logic          memWe;
  logic [IW-1:0] memIdx;
  logic [31:0]   memData;
  logic [3:0]    memBe;
  logic [IW-1:0] cpuIdx;

  assign cpuIdx    = cpuAddr[IW+1:2];
  assign cpuGnt    = cpuReq && !traceBusy;
  assign memWe     = traceWe || (cpuGnt && cpuWe);
  assign memIdx    = traceWe ? traceIdx : cpuIdx;
  assign memData   = traceWe ? traceData : cpuWdata;
  assign memBe     = traceWe ? trace_pkg::ALL_BYTES : cpuBe;
  assign cpuRvalid = cpuRvalid_q;
  assign cpuRdata  = cpuRdata_q;

  always_ff @(posedge ref_clk) begin
    if (memWe) begin
      sram[memIdx] <= mergeBytes(sram[memIdx], memData, memBe);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuRvalid_q <= 1'h0;
      cpuRdata_q  <= 32'h0;
    end else begin
      cpuRvalid_q <= cpuGnt && !cpuWe;
      if (cpuGnt && !cpuWe) begin
        cpuRdata_q <= sram[cpuIdx];
      end
    end
  end

  // ==========================================================
  // control register updates
  // a software pointer write beats the advance of the same cycle, but a wrap event of that cycle beats the written wrap bit
  logic                         en_d;
  logic [trace_pkg::MASK_W-1:0] mask_d;
  logic [PW-1:3]                posPtr_d;
  logic                         posWrap_d;
  logic [PW-1:3]                wmark_d;
  logic                         auto_stop_select_d;
  logic                         auto_halt_select_d;
  logic                         haltReq_d;

  assign en_d       = (wmHit && auto_stop_select_q) ? 1'h0 :
                      wrMaster ? wrNew[trace_pkg::MASTER_EN_BIT] : en_q;
  assign mask_d     = wrMaster ? wrNew[trace_pkg::MASK_LSB +: trace_pkg::MASK_W] : mask_q;
  assign posPtr_d   = wrPos ? wrNew[PW-1:trace_pkg::PTR_LSB] :
                      pktDone ? ptrNext[PW-1:3] : posPtr_q;
  assign posWrap_d  = (pktDone && wrapEv) ? 1'h1 :
                      wrPos ? wrNew[trace_pkg::POS_WRAP_BIT] : posWrap_q;
  assign wmark_d    = wrFlow ? wrNew[PW-1:trace_pkg::PTR_LSB] : wmark_q;
  assign auto_stop_select_d = wrFlow ? wrNew[trace_pkg::FLOW_STOP_BIT] : auto_stop_select_q;
  assign auto_halt_select_d = wrFlow ? wrNew[trace_pkg::FLOW_HALT_BIT] : auto_halt_select_q;
  assign haltReq_d  = (wmHit && auto_halt_select_q) ? 1'h1 :
                      wrFlow ? 1'h0 : haltReq_q;
  assign haltReq    = haltReq_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q       <= trace_pkg::EN_RST;
      mask_q     <= trace_pkg::MASK_RST;
      posPtr_q   <= '0;
      posWrap_q  <= 1'h0;
      wmark_q    <= '0;
      auto_stop_select_q <= 1'h0;
      auto_halt_select_q <= 1'h0;
      haltReq_q  <= 1'h0;
    end else begin
      en_q       <= en_d;
      mask_q     <= mask_d;
      posPtr_q   <= posPtr_d;
      posWrap_q  <= posWrap_d;
      wmark_q    <= wmark_d;
      auto_stop_select_q <= auto_stop_select_d;
      auto_halt_select_q <= auto_halt_select_d;
      haltReq_q  <= haltReq_d;
    end
  end

endmodule
`default_nettype wire

// ### dv/program_trace_buffer_properties.sv
// port-level checks for the program flow trace buffer
`timescale 1ns/1ps
`default_nettype none
module program_trace_buffer_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic traceValid,
  input wire logic traceReady,
  input wire logic cpuReq,
  input wire logic cpuWe,
  input wire logic cpuGnt,
  input wire logic cpuRvalid,
  input wire logic haltReq,
  input wire logic traceActive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ======
  // trace and sram arbitration
  a_ready_needs_enable: assert property (traceReady |-> traceActive)
    else $error("trace taken while off");
  a_trace_beats_cpu: assert property (traceValid && traceReady |=> !cpuGnt)
    else $error("cpu granted over pending trace");
  a_grant_needs_req: assert property (cpuGnt |-> cpuReq)
    else $error("grant without request");
  // fifo leftovers may still drain after disable, hence the slack
  a_cpu_served_idle: assert property (cpuReq && !traceActive |-> ##[0:12] cpuGnt)
    else $error("cpu starved while idle");
  a_read_answer: assert property (cpuReq && cpuGnt && !cpuWe |=> cpuRvalid)
    else $error("no sram read answer");
  a_rvalid_cause: assert property (cpuRvalid |-> $past(cpuGnt) && !$past(cpuWe))
    else $error("read answer without read");
  // ======
  // register bus and halt
  a_write_resp: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_read_resp: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  a_halt_clear: assert property ($fell(haltReq) |-> $rose(bvalid))
    else $error("halt dropped without write");
  a_halt_cause: assert property ($rose(haltReq) |-> !$past(cpuGnt))
    else $error("halt without trace write");
endmodule
bind program_trace_buffer program_trace_buffer_checker chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .traceValid(traceValid), .traceReady(traceReady),
  .cpuReq(cpuReq), .cpuWe(cpuWe), .cpuGnt(cpuGnt), .cpuRvalid(cpuRvalid),
  .haltReq(haltReq), .traceActive(traceActive));
`default_nettype wire

// ### dv/core_model.sv
// processor-side model: trace packet source and sram requester
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic        ref_clk,
  output logic             traceValid,
  input  wire logic        traceReady,
  output logic [31:0]      traceSrcPc,
  output logic [31:0]      traceDstPc,
  output logic             traceException,
  output logic             cpuReq,
  output logic             cpuWe,
  output logic [31:0]      cpuAddr,
  output logic [31:0]      cpuWdata,
  output logic [3:0]       cpuBe,
  input  wire logic        cpuGnt,
  input  wire logic        cpuRvalid,
  input  wire logic [31:0] cpuRdata
);
  logic [64:0] pktQ[$];
  initial begin
    {traceValid, traceSrcPc, traceDstPc, traceException} = '0;
    {cpuReq, cpuWe, cpuAddr, cpuWdata, cpuBe} = '0;
  end
  // ======
  // trace offers: payload held until taken, inverted once released
  always @(posedge ref_clk) begin
    if (!traceValid || traceReady) begin
      if (pktQ.size() > 0) begin
        {traceSrcPc, traceDstPc, traceException} <= pktQ.pop_front();
        traceValid <= 1'b1;
      end else if (traceValid) begin
        traceValid <= 1'b0;
        traceSrcPc <= ~traceSrcPc;
        traceDstPc <= ~traceDstPc;
        traceException <= ~traceException;
      end
    end
  end
  // ======
  // sram access as processor or debug port, held until granted
  task automatic acc(input logic we, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    cpuReq <= 1'b1;
    cpuWe <= we;
    cpuAddr <= a;
    cpuWdata <= d;
    cpuBe <= 4'hf;
    for (n = 0; n < 200; n++) begin
      @(posedge ref_clk);
      if (cpuGnt) break;
    end
    cpuReq <= 1'b0;
    cpuAddr <= ~a;
    cpuWdata <= ~d;
    @(posedge ref_clk);
    // an unanswered request reads as unknown, so its compare fails
    q = (n < 200) ? cpuRdata : 'x;
  endtask
endmodule
`default_nettype wire

// ### dv/tb_program_trace_buffer.sv
// self-checking bench for the program flow trace buffer
`timescale 1ns/1ps
`default_nettype none
module tb_program_trace_buffer;
  localparam logic [31:0] SRAM_BASE = 32'h2000_4000;
  logic        ref_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, traceValid, traceReady, traceException;
  logic        cpuReq, cpuWe, cpuGnt, cpuRvalid, haltReq, traceActive;
  logic [31:0] awaddr, wdata, araddr, rdata, traceSrcPc, traceDstPc;
  logic [31:0] cpuAddr, cpuWdata, cpuRdata, v;
  logic [3:0]  wstrb, cpuBe;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] srcA [0:4] = '{32'h1000_0011, 32'h1000_0203, 32'h1000_0305,
                              32'h1000_0407, 32'h1000_0509};
  logic [31:0] dstA [0:4] = '{32'h1000_0100, 32'h0000_00c1, 32'h1000_0401,
                              32'h1000_0601, 32'h1000_0703};
  logic        excA [0:4] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int          error_cnt, checked, k;

  program_trace_buffer #(.SRAM_MAP_BASE(SRAM_BASE)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .traceValid(traceValid), .traceReady(traceReady),
    .traceSrcPc(traceSrcPc), .traceDstPc(traceDstPc), .traceException(traceException),
    .cpuReq(cpuReq), .cpuWe(cpuWe), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuBe(cpuBe),
    .cpuGnt(cpuGnt), .cpuRvalid(cpuRvalid), .cpuRdata(cpuRdata), .haltReq(haltReq),
    .traceActive(traceActive));

  core_model core_u (
    .ref_clk(ref_clk), .traceValid(traceValid), .traceReady(traceReady),
    .traceSrcPc(traceSrcPc), .traceDstPc(traceDstPc), .traceException(traceException),
    .cpuReq(cpuReq), .cpuWe(cpuWe), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuBe(cpuBe),
    .cpuGnt(cpuGnt), .cpuRvalid(cpuRvalid), .cpuRdata(cpuRdata));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ======
  // bus tasks and comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] off, input logic [31:0] d, output logic [1:0] rs);
    int n;
    bit ad, wd;
    awaddr <= trace_pkg::REG_BASE + {20'h0, off};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    for (n = 0; n < 50 && !(ad && wd); n++) begin
      @(posedge ref_clk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (bvalid) break;
    end
    if (!bvalid) error_cnt++;
    rs = bresp;
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] off, output logic [31:0] d, output logic [1:0] rs);
    int n;
    araddr <= trace_pkg::REG_BASE + {20'h0, off};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arready) break;
    end
    arvalid <= 1'b0;
    while (!rvalid && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (!rvalid) error_cnt++;
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ======
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    test_done();
  end
  // ======
  // scenarios
  initial begin
    rst_n = 1'b0;
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(trace_pkg::POS_OFF, v, r);     chk(v, 32'h0);
    rd(trace_pkg::MASTER_OFF, v, r);  chk(v, 32'h0);
    rd(trace_pkg::FLOW_OFF, v, r);    chk(v, 32'h0);
    wr(trace_pkg::BASE_OFF, 32'h0, r); chk({30'h0, r}, 32'h0);
    rd(trace_pkg::BASE_OFF, v, r);    chk(v, SRAM_BASE);
    rd(12'h010, v, r);                chk({30'h0, r}, 32'h2);
    wr(12'h010, 32'h1, r);            chk({30'h0, r}, 32'h2);
    core_u.acc(1'b1, 32'h300, 32'h5a5a_0f0f, v);
    // 16-byte region at 0x100: third packet overwrites the first
    wr(trace_pkg::POS_OFF, 32'h100, r);
    wr(trace_pkg::MASTER_OFF, 32'h8000_0000, r);
    chk({31'h0, traceActive}, 32'h1);
    for (k = 0; k < 3; k++) core_u.pktQ.push_back({srcA[k], dstA[k], excA[k]});
    repeat (2) @(posedge ref_clk);
    core_u.acc(1'b0, 32'h300, 32'h0, v); chk(v, 32'h5a5a_0f0f);
    for (k = 1; k < 3; k++) begin
      v = (k == 2) ? 32'h100 : 32'h108;
      core_u.acc(1'b0, v, 32'h0, v);
      chk(v, {srcA[k][31:1], excA[k]});
      core_u.acc(1'b0, (k == 2) ? 32'h104 : 32'h10c, 32'h0, v);
      chk(v, {dstA[k][31:1], 1'b0});
    end
    rd(trace_pkg::POS_OFF, v, r); chk(v, 32'h10c);
    // disabled: the offer must wait untouched
    wr(trace_pkg::MASTER_OFF, 32'h0, r); chk({31'h0, traceActive}, 32'h0);
    for (k = 3; k < 5; k++) core_u.pktQ.push_back({srcA[k], dstA[k], excA[k]});
    repeat (4) @(posedge ref_clk);
    chk({31'h0, traceReady}, 32'h0);
    rd(trace_pkg::POS_OFF, v, r); chk(v, 32'h10c);
    // 64-byte region at 0x200, watermark 0x210 with stop and halt
    wr(trace_pkg::POS_OFF, 32'h200, r);
    wr(trace_pkg::FLOW_OFF, 32'h213, r);
    wr(trace_pkg::MASTER_OFF, 32'h8000_0002, r);
    core_u.acc(1'b0, 32'h200, 32'h0, v); chk(v, {srcA[3][31:1], excA[3]});
    core_u.acc(1'b0, 32'h20c, 32'h0, v); chk(v, {dstA[4][31:1], 1'b0});
    chk({30'h0, haltReq, traceActive}, 32'h2);
    rd(trace_pkg::MASTER_OFF, v, r); chk(v, 32'h2);
    rd(trace_pkg::POS_OFF, v, r);    chk(v, 32'h210);
    rd(trace_pkg::FLOW_OFF, v, r);   chk(v, 32'h213);
    chk({30'h0, r}, 32'h0);
    wr(trace_pkg::FLOW_OFF, 32'h0, r); chk({31'h0, haltReq}, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
